// file: shared/fullcan_pkg.sv
package fullcan_pkg;
   localparam int ADDR_W = 11;
   localparam int RAM_WORDS = 512;
   localparam int ID_W = 11;
   localparam int CTRL_W = 3;
   localparam int EVEN_CTRL_LSB = 29;
   localparam int EVEN_DIS_BIT = 28;
   localparam int EVEN_ID_LSB = 16;
   localparam int ODD_CTRL_LSB = 13;
   localparam int ODD_DIS_BIT = 12;
   localparam int ODD_ID_LSB = 0;
   localparam int OBJ_BYTES = 12;
   localparam int OBJ_FF_BIT = 31;
   localparam int OBJ_RTR_BIT = 30;
   localparam int OBJ_SEM_LSB = 24;
   localparam int OBJ_DLC_LSB = 16;
   localparam int OBJ_DATA1_OFS = 4;
   localparam int OBJ_DATA2_OFS = 8;
   localparam logic [1:0] SEM_UPDATING = 2'h1;
   localparam logic [1:0] SEM_DONE = 2'h3;
   localparam logic [1:0] SEM_READ = 2'h0;
   localparam logic [ADDR_W-1:0] RST_OFS = 11'h000;
   localparam logic RST_ENABLE = 1'b0;
endpackage

// file: shared/fullcan_if.sv
// Word access to the shared look-up RAM plus the received frame handoff.
interface fullcan_if (
   input wire logic clk_sys,
   input wire logic nrst
);
   import fullcan_pkg::*;
   logic fullcan_enable;
   logic [ADDR_W-1:0] std_explicit_start;
   logic [ADDR_W-1:0] object_section_offset;
   logic rx_valid;
   logic rx_ack;
   logic rx_matched;
   logic [CTRL_W-1:0] rx_ctrl;
   logic rx_ext;
   logic rx_rtr;
   logic [6:0] length_code;
   logic [ID_W-1:0] rx_id;
   logic [63:0] rx_data;
   logic cpu_req;
   logic cpu_we;
   logic [ADDR_W-1:0] cpu_addr;
   logic [31:0] cpu_wdata;
   logic [31:0] cpu_rdata;
   logic cpu_ack;
   modport filter (
      input fullcan_enable, std_explicit_start, object_section_offset,
      input rx_valid, rx_ctrl, rx_ext, rx_rtr, length_code, rx_id, rx_data,
      output rx_ack, rx_matched,
      input cpu_req, cpu_we, cpu_addr, cpu_wdata,
      output cpu_rdata, cpu_ack
   );
   modport cpu (
      output fullcan_enable, std_explicit_start, object_section_offset,
      output rx_valid, rx_ctrl, rx_ext, rx_rtr, length_code, rx_id, rx_data,
      input rx_ack, rx_matched,
      output cpu_req, cpu_we, cpu_addr, cpu_wdata,
      input cpu_rdata, cpu_ack
   );
endinterface

// file: hdl/entry_match.sv
// Compares one table word, both halves, against the received frame.
module entry_match (
   // Table word
   input wire logic [31:0] word,
   // Received frame
   input wire logic [fullcan_pkg::CTRL_W-1:0] ctrl,
   input wire logic [fullcan_pkg::ID_W-1:0] id,
   // Results
   output logic hit_even,
   output logic hit_odd,
   output logic past_odd
);
   import fullcan_pkg::*;
   function automatic logic half_hit(input logic [CTRL_W-1:0] c,
                                     input logic d,
                                     input logic [ID_W-1:0] i);
      half_hit = !d && c == ctrl && i == id;
   endfunction
   always_comb begin
      hit_even = half_hit(word[EVEN_CTRL_LSB +: CTRL_W],
                          word[EVEN_DIS_BIT],
                          word[EVEN_ID_LSB +: ID_W]);
      hit_odd = half_hit(word[ODD_CTRL_LSB +: CTRL_W],
                         word[ODD_DIS_BIT],
                         word[ODD_ID_LSB +: ID_W]);
      // Ascending order lets the scan stop once an entry passes the key.
      past_odd = {word[ODD_CTRL_LSB +: CTRL_W], word[ODD_ID_LSB +: ID_W]}
                 > {ctrl, id};
   end
endmodule // entry_match

// file: hdl/fullcan_filter.sv
// Filter end: scans FullCAN entries and writes message objects into RAM.
module fullcan_filter (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link
   fullcan_if.filter bus
);
   import fullcan_pkg::*;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_SCAN = 3'h1, S_W0 = 3'h3, S_W1 = 3'h2,
      S_W2 = 3'h6, S_DONE = 3'h7, S_ACK = 3'h5
   } state_e;
   logic [31:0] ram [RAM_WORDS];
   state_e state_q;
   logic [ADDR_W-1:0] ptr_q;
   logic [ADDR_W:0] idx_q;
   logic [ADDR_W-1:0] obj_q;
   logic hit_q;
   logic rx_ack_q;
   logic cpu_ack_q;
   logic [31:0] cpu_rdata_q;
   logic hit_even, hit_odd, past_odd;
   logic [31:0] scan_word;
   logic [ADDR_W+3:0] obj_calc;
   logic [ADDR_W-1:0] waddr;
   logic [31:0] wdata;
   logic we;
   assign scan_word = ram[ptr_q[ADDR_W-1:2]];
   entry_match u_match (
      .word(scan_word),
      .ctrl(bus.rx_ctrl),
      .id(bus.rx_id),
      .hit_even(hit_even),
      .hit_odd(hit_odd),
      .past_odd(past_odd)
   );
   assign obj_calc = {4'h0, bus.object_section_offset}
                     + (ADDR_W+4)'(OBJ_BYTES) * {3'h0, idx_q};
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state_q <= S_IDLE;
         ptr_q <= RST_OFS;
         idx_q <= '0;
         obj_q <= RST_OFS;
         hit_q <= 1'b0;
      end else begin
         case (state_q)
            S_IDLE: begin
               ptr_q <= RST_OFS;
               idx_q <= '0;
               hit_q <= 1'b0;
               if (bus.rx_valid) begin
                  // Extended frames and a disabled mode skip this section.
                  if (bus.fullcan_enable && !bus.rx_ext)
                     state_q <= S_SCAN;
                  else state_q <= S_ACK;
               end
            end
            S_SCAN: begin
               if (ptr_q >= bus.std_explicit_start) begin
                  state_q <= S_ACK;
               end else if (hit_even || hit_odd) begin
                  obj_q <= obj_calc[ADDR_W-1:0] + (hit_even ? '0
                           : ADDR_W'(OBJ_BYTES));
                  hit_q <= 1'b1;
                  state_q <= S_W0;
               end else if (past_odd) begin
                  state_q <= S_ACK;
               end else begin
                  ptr_q <= ptr_q + ADDR_W'(4);
                  idx_q <= idx_q + (ADDR_W+1)'(2);
               end
            end
            S_W0: state_q <= S_W1;
            S_W1: state_q <= S_W2;
            S_W2: state_q <= S_DONE;
            S_DONE: state_q <= S_ACK;
            S_ACK: if (!bus.rx_valid) state_q <= S_IDLE;
            default: state_q <= S_IDLE;
         endcase
      end
   end
   always_comb begin
      we = 1'b0;
      waddr = obj_q;
      wdata = '0;
      case (state_q)
         S_W0: begin
            we = 1'b1;
            wdata[OBJ_FF_BIT] = bus.rx_ext;
            wdata[OBJ_RTR_BIT] = bus.rx_rtr;
            wdata[OBJ_SEM_LSB +: 2] = SEM_UPDATING;
            wdata[OBJ_DLC_LSB +: 7] = bus.length_code;
            wdata[ID_W-1:0] = bus.rx_id;
         end
         S_W1: begin
            we = 1'b1;
            waddr = obj_q + ADDR_W'(OBJ_DATA1_OFS);
            wdata = bus.rx_data[31:0];
         end
         S_W2: begin
            we = 1'b1;
            waddr = obj_q + ADDR_W'(OBJ_DATA2_OFS);
            wdata = bus.rx_data[63:32];
         end
         S_DONE: begin
            we = 1'b1;
            wdata = ram[obj_q[ADDR_W-1:2]];
            wdata[OBJ_SEM_LSB +: 2] = SEM_DONE;
         end
         default: we = 1'b0;
      endcase
   end
   // The filter owns the RAM port while writing; the CPU waits until we drops, up to four cycles.
   always_ff @(posedge clk_sys) begin
      if (we) ram[waddr[ADDR_W-1:2]] <= wdata;
      else if (bus.cpu_req && bus.cpu_we && !cpu_ack_q)
         ram[bus.cpu_addr[ADDR_W-1:2]] <= bus.cpu_wdata;
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cpu_ack_q <= 1'b0;
         cpu_rdata_q <= '0;
      end else begin
         cpu_ack_q <= bus.cpu_req && !we && !cpu_ack_q;
         if (bus.cpu_req && !we && !cpu_ack_q)
            cpu_rdata_q <= ram[bus.cpu_addr[ADDR_W-1:2]];
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) rx_ack_q <= 1'b0;
      // One-cycle pulse, repeated every other cycle while the frame is still held in S_ACK.
      else rx_ack_q <= state_q == S_ACK && bus.rx_valid && !rx_ack_q;
   end
   assign bus.rx_ack = rx_ack_q;
   assign bus.rx_matched = hit_q;
   assign bus.cpu_ack = cpu_ack_q;
   assign bus.cpu_rdata = cpu_rdata_q;
endmodule // fullcan_filter

// file: hdl/fullcan_cpu.sv
// CPU end: configures, hands over frames and reads objects by semaphore.
module fullcan_cpu (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link
   fullcan_if.cpu bus,
   // Configuration
   input wire logic cfg_enable,
   input wire logic [fullcan_pkg::ADDR_W-1:0] cfg_explicit_start,
   input wire logic [fullcan_pkg::ADDR_W-1:0] cfg_object_offset,
   // Table load, closed by rd_done as well.
   input wire logic tbl_we,
   input wire logic [fullcan_pkg::ADDR_W-1:0] tbl_addr,
   input wire logic [31:0] tbl_wdata,
   // Frame injection
   input wire logic frm_valid,
   input wire logic [fullcan_pkg::CTRL_W-1:0] frm_ctrl,
   input wire logic frm_ext,
   input wire logic frm_rtr,
   input wire logic [6:0] frm_len,
   input wire logic [fullcan_pkg::ID_W-1:0] frm_id,
   input wire logic [63:0] frm_data,
   output logic frm_done,
   // Object read
   input wire logic rd_start,
   input wire logic [fullcan_pkg::ADDR_W-1:0] rd_base,
   output logic rd_done,
   output logic rd_ok,
   output logic [31:0] rd_w0,
   output logic [63:0] rd_data
);
   import fullcan_pkg::*;
   typedef enum logic [2:0] {
      C_IDLE = 3'h0, C_CHK = 3'h1, C_CLR = 3'h3, C_RD1 = 3'h2,
      C_RD2 = 3'h6, C_RECHK = 3'h7, C_FIN = 3'h5, C_LOAD = 3'h4
   } cstate_e;
   cstate_e st_q;
   logic req_q, we_q, done_q, ok_q, fd_q, fv_q;
   logic [ADDR_W-1:0] addr_q;
   logic [31:0] wd_q, w0_q;
   logic [63:0] data_q;
   logic [1:0] sem;
   assign sem = bus.cpu_rdata[OBJ_SEM_LSB +: 2];
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st_q <= C_IDLE;
         req_q <= 1'b0;
         we_q <= 1'b0;
         addr_q <= RST_OFS;
         wd_q <= '0;
         w0_q <= '0;
         data_q <= '0;
         done_q <= 1'b0;
         ok_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         case (st_q)
            C_IDLE: begin
               if (rd_start) begin
                  addr_q <= rd_base;
                  req_q <= 1'b1;
                  we_q <= 1'b0;
                  st_q <= C_CHK;
               end else if (tbl_we) begin
                  // The RAM is not reset, so the table arrives this way.
                  addr_q <= tbl_addr;
                  wd_q <= tbl_wdata;
                  req_q <= 1'b1;
                  we_q <= 1'b1;
                  st_q <= C_LOAD;
               end
            end
            C_LOAD: if (bus.cpu_ack) begin
               req_q <= 1'b0;
               we_q <= 1'b0;
               st_q <= C_FIN;
            end
            C_CHK: if (bus.cpu_ack) begin
               if (sem == SEM_DONE) begin
                  w0_q <= bus.cpu_rdata;
                  wd_q <= bus.cpu_rdata & ~(32'h3 << OBJ_SEM_LSB);
                  we_q <= 1'b1;
                  st_q <= C_CLR;
               end else begin
                  req_q <= 1'b0;
                  ok_q <= 1'b0;
                  st_q <= C_FIN;
               end
            end
            C_CLR: if (bus.cpu_ack) begin
               we_q <= 1'b0;
               addr_q <= addr_q + ADDR_W'(OBJ_DATA1_OFS);
               st_q <= C_RD1;
            end
            C_RD1: if (bus.cpu_ack) begin
               data_q[31:0] <= bus.cpu_rdata;
               addr_q <= addr_q + ADDR_W'(OBJ_DATA1_OFS);
               st_q <= C_RD2;
            end
            C_RD2: if (bus.cpu_ack) begin
               data_q[63:32] <= bus.cpu_rdata;
               addr_q <= addr_q - ADDR_W'(OBJ_DATA2_OFS);
               st_q <= C_RECHK;
            end
            C_RECHK: if (bus.cpu_ack) begin
               req_q <= 1'b0;
               ok_q <= sem == SEM_READ;
               st_q <= C_FIN;
            end
            C_FIN: begin
               done_q <= 1'b1;
               st_q <= C_IDLE;
            end
            default: st_q <= C_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         fv_q <= 1'b0;
         fd_q <= 1'b0;
      end else begin
         fd_q <= 1'b0;
         if (!fv_q && frm_valid) fv_q <= 1'b1;
         else if (fv_q && bus.rx_ack) begin
            fv_q <= 1'b0;
            fd_q <= 1'b1;
         end
      end
   end
   assign bus.fullcan_enable = cfg_enable;
   assign bus.std_explicit_start = cfg_explicit_start;
   assign bus.object_section_offset = cfg_object_offset;
   assign bus.rx_valid = fv_q;
   assign bus.rx_ctrl = frm_ctrl;
   assign bus.rx_ext = frm_ext;
   assign bus.rx_rtr = frm_rtr;
   assign bus.length_code = frm_len;
   assign bus.rx_id = frm_id;
   assign bus.rx_data = frm_data;
   assign bus.cpu_req = req_q;
   assign bus.cpu_we = we_q;
   assign bus.cpu_addr = addr_q;
   assign bus.cpu_wdata = wd_q;
   assign frm_done = fd_q;
   assign rd_done = done_q;
   assign rd_ok = ok_q;
   assign rd_w0 = w0_q;
   assign rd_data = data_q;
endmodule // fullcan_cpu

// file: tb/fullcan_checker.sv
// Watches the frame handoff between the two design ends.
module fullcan_checker (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Link signals
   input wire logic fullcan_enable,
   input wire logic rx_valid,
   input wire logic rx_ext,
   input wire logic rx_ack,
   input wire logic rx_matched
);
   import fullcan_pkg::*;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   ack_one_cycle_a: assert property (rx_ack |=> !rx_ack)
      else $error("Frame acknowledge held longer than one cycle.");
   off_no_match_a: assert property (
      rx_ack && !fullcan_enable |-> !rx_matched)
      else $error("Match reported while the mode is off.");
   ext_no_match_a: assert property (rx_ack && rx_ext |-> !rx_matched)
      else $error("Match reported for an extended frame.");
   ack_held_frame_a: assert property (rx_ack |-> rx_valid)
      else $error("Acknowledge without a held frame.");
   ack_bounded_a: assert property ($rose(rx_valid) |-> ##[1:600] rx_ack)
      else $error("Frame never acknowledged.");
   section_ignored_a: assert property (
      $rose(rx_valid) && !fullcan_enable |-> ##[1:12] rx_ack)
      else $error("Section scanned while the mode is off.");
   match_after_write_a: assert property (
      rx_ack && rx_matched |-> $past(rx_valid, 7))
      else $error("Match answered before the object was written.");
   ack_latency_a: assert property ($rose(rx_ack) |-> $past(rx_valid, 2))
      else $error("Acknowledge came too soon.");
endmodule // fullcan_checker

// file: tb/fullcan_filter_object_store_tb.sv
module fullcan_filter_object_store_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fullcan_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   logic [31:0] rng = 32'h00016102;
   logic cfg_enable, frm_valid, frm_ext, frm_rtr, frm_done, rd_done, rd_ok;
   logic rd_start, tbl_we;
   logic [ADDR_W-1:0] cfg_start, cfg_obj, rd_base, tbl_addr;
   logic [31:0] tbl_wdata;
   logic [CTRL_W-1:0] frm_ctrl;
   logic [6:0] frm_len;
   logic [ID_W-1:0] frm_id;
   logic [63:0] frm_data, rd_data;
   logic [31:0] rd_w0;
   logic [2:0] t_ctrl [4] = '{3'h1, 3'h1, 3'h2, 3'h2};
   logic [10:0] t_id [4] = '{11'h100, 11'h120, 11'h050, 11'h300};
   logic t_dis [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
   fullcan_if bus (.clk_sys(clk_sys), .nrst(nrst));
   fullcan_cpu fullcan_cpu_i (.clk_sys(clk_sys), .nrst(nrst), .bus(bus),
      .cfg_enable(cfg_enable), .cfg_explicit_start(cfg_start),
      .cfg_object_offset(cfg_obj), .tbl_we(tbl_we), .tbl_addr(tbl_addr),
      .tbl_wdata(tbl_wdata), .frm_valid(frm_valid),
      .frm_ctrl(frm_ctrl), .frm_ext(frm_ext), .frm_rtr(frm_rtr),
      .frm_len(frm_len), .frm_id(frm_id), .frm_data(frm_data),
      .frm_done(frm_done), .rd_start(rd_start), .rd_base(rd_base),
      .rd_done(rd_done), .rd_ok(rd_ok), .rd_w0(rd_w0), .rd_data(rd_data));
   fullcan_filter fullcan_filter_i (.clk_sys(clk_sys), .nrst(nrst),
      .bus(bus));
   fullcan_checker fullcan_checker_i (.clk_sys(clk_sys), .nrst(nrst),
      .fullcan_enable(bus.fullcan_enable), .rx_valid(bus.rx_valid),
      .rx_ext(bus.rx_ext), .rx_ack(bus.rx_ack),
      .rx_matched(bus.rx_matched));
   function automatic logic [31:0] xs();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction
   function automatic int lookup(logic [2:0] c, logic [10:0] i);
      for (int k = 0; k < 4; k++) begin
         if (!t_dis[k] && t_ctrl[k] == c && t_id[k] == i) return k;
      end
      return -1;
   endfunction
   function automatic logic [31:0] obj_w0(logic t, logic [6:0] l,
         logic [10:0] i);
      return {1'b0, t, 4'h0, SEM_DONE, 1'b0, l, 5'h00, i};
   endfunction
   task automatic check(string what, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      if (fail_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Each request is a one-cycle strobe that the idle end latches.
   task automatic load(logic [10:0] a, logic [31:0] d);
      @(posedge clk_sys);
      #1;
      tbl_addr = a;
      tbl_wdata = d;
      tbl_we = 1'b1;
      @(posedge clk_sys);
      #1;
      tbl_we = 1'b0;
      repeat (20) begin
         @(posedge clk_sys);
         if (rd_done === 1'b1) break;
      end
      check("load_done", rd_done, 1'b1);
      #1;
   endtask
   task automatic read_obj(logic [10:0] a);
      @(posedge clk_sys);
      #1;
      rd_base = a;
      rd_start = 1'b1;
      @(posedge clk_sys);
      #1;
      rd_start = 1'b0;
      repeat (40) begin
         @(posedge clk_sys);
         if (rd_done === 1'b1) break;
      end
      check("rd_done", rd_done, 1'b1);
      #1;
   endtask
   task automatic send(logic [2:0] c, logic [10:0] i, logic x, logic t,
         logic [6:0] l, logic [63:0] d, output logic m);
      @(posedge clk_sys);
      #1;
      frm_ctrl = c;
      frm_id = i;
      frm_ext = x;
      frm_rtr = t;
      frm_len = l;
      frm_data = d;
      frm_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      frm_valid = 1'b0;
      m = 1'b0;
      repeat (700) begin
         @(posedge clk_sys);
         m = bus.rx_matched;
         if (frm_done === 1'b1) break;
      end
      check("frm_done", frm_done, 1'b1);
      #1;
   endtask
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   initial begin
      #400000;
      fail_count++;
      finish_test();
   end
   initial begin
      logic [31:0] r, e0;
      logic [2:0] c;
      logic [10:0] i, a;
      logic x, m, em;
      logic [63:0] d;
      int idx;
      {cfg_enable, frm_valid, frm_ext, frm_rtr, frm_ctrl, frm_len} = '0;
      {frm_id, frm_data, rd_start, rd_base, tbl_we, tbl_addr, tbl_wdata} = '0;
      cfg_start = 11'h008;
      cfg_obj = 11'h040;
      repeat (2) @(posedge clk_sys);
      #1;
      nrst = 1'b1;
      for (int w = 0; w < 2; w++) begin
         load(11'(4 * w), {t_ctrl[2*w], t_dis[2*w], 1'b0, t_id[2*w],
            t_ctrl[2*w+1], t_dis[2*w+1], 1'b0, t_id[2*w+1]});
      end
      // Corner keys first: hits, a disabled entry, a wrong controller.
      // The last two frames meet a short section and the mode off.
      for (int n = 0; n < 24; n++) begin
         r = xs();
         c = (n < 4) ? t_ctrl[n] : (n < 6) ? 3'h3 : 3'(r[0] + 1);
         i = (n < 6) ? t_id[n % 4] : r[1] ? t_id[r[3:2]] : r[14:4];
         x = (n > 5) && (n < 22) && (r[15:13] == 3'h0);
         if (n > 21) begin
            c = t_ctrl[(23 - n) * 2];
            i = t_id[(23 - n) * 2];
         end
         cfg_enable = (n != 23);
         cfg_start = (n == 22) ? 11'h004 : 11'h008;
         d = {xs(), xs()};
         idx = lookup(c, i);
         em = cfg_enable && !x && idx >= 0 && idx < int'(cfg_start) / 2;
         send(c, i, x, r[16], {3'h0, r[20:17]}, d, m);
         check("rx_matched", m, em);
         if (em) begin
            a = cfg_obj + 11'(12 * idx);
            e0 = obj_w0(r[16], {3'h0, r[20:17]}, i);
            read_obj(a);
            check("rd_ok", rd_ok, 1'b1);
            check("word0", rd_w0, e0);
            check("data1", rd_data[31:0], d[31:0]);
            check("data2", rd_data[63:32], d[63:32]);
            read_obj(a);
            check("sem", rd_ok, 1'b0);
         end
      end
      read_obj(cfg_obj);
      check("sem_off", rd_ok, 1'b0);
      finish_test();
   end
endmodule // fullcan_filter_object_store_tb
